// file: hw/vds_monitor_defines.svh
`ifndef VDS_MONITOR_DEFINES_SVH
`define VDS_MONITOR_DEFINES_SVH

`define CLK_PERIOD_NS      40
// register byte offsets
`define OFF_THR_A          8'h00
`define OFF_THR_B          8'h04
`define OFF_GEN_CTRL_TWO   8'h08
`define OFF_DRAIN_REF      8'h0C
`define OFF_BLANK_SEL_LO   8'h10
`define OFF_BLANK_SEL_HI   8'h14
`define OFF_STATIC_CFG     8'h18
`define OFF_FAULT_STATUS   8'h1C
`define OFF_IRQ_MASK       8'h20
`define OFF_GLOBAL_STATUS  8'h24
`define OFF_PIN_STATE      8'h28
// field positions
`define GC2_FILTER_LSB     0
`define GC2_PASSIVE_BIT    2
`define GS_GLOBAL_DRAIN_SOURCE_ERROR_BIT        0
// reset values
`define RST_THR_A          32'h00000249
`define RST_THR_B          32'h00000249
`define RST_GEN_CTRL_TWO   32'h00000000
`define RST_BLANK_SEL      32'h44444444
`define RST_STATIC_CFG     32'h00000000
// timing in ns, as typical figures
`define FILT_T0_NS         500
`define FILT_T1_NS         1000
`define FILT_T2_NS         2000
`define FILT_T3_NS         3000
`define BLANK_T0_NS        625
`define BLANK_T1_NS        1000
`define BLANK_T2_NS        1250
`define BLANK_T3_NS        1500
`define BLANK_T4_NS        2000
`define BLANK_T5_NS        3000
`define BLANK_T6_NS        4000
`define BLANK_T7_NS        16000
// least times round up to whole cycles
`define NS_TO_CYC(t)       (((t) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// file: hw/vds_pkg.sv
package vds_pkg;
  typedef enum logic [1:0] {
    ST_OFF,
    ST_BLANK,
    ST_MONITOR,
    ST_LATCHED
  } bridge_state_e;
  typedef logic [2:0] thr_code_t;
endpackage

// file: hw/vds_channel.sv
`timescale 1ns/1ps
`include "vds_monitor_defines.svh"
// one half-bridge: blanking, filter, latch-off
module vds_channel (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        active_mode,
  input  wire logic        hs_on_cmd,
  input  wire logic        ls_on_cmd,
  input  wire logic        overvoltage,
  input  wire logic [9:0]  blank_cycles,
  input  wire logic [6:0]  filter_cycles,
  input  wire logic        fault_clear,
  output logic             fault_event,
  output logic             latched,
  output logic             monitoring
);
  vds_pkg::bridge_state_e state_reg;
  logic [9:0]             blank_cnt_reg;
  logic [7:0]             filt_cnt_reg;
  logic                   on_now;
  logic                   pre_short_reg;
  logic [7:0]             filt_limit;

  assign on_now = (hs_on_cmd | ls_on_cmd) & active_mode;
  // short present during blanking needs twice the filter time
  assign filt_limit = pre_short_reg ? {filter_cycles, 1'b0} : {1'b0, filter_cycles};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg     <= vds_pkg::ST_OFF;
      blank_cnt_reg <= 10'h000;
      filt_cnt_reg  <= 8'h00;
      pre_short_reg <= 1'b0;
      fault_event   <= 1'b0;
    end else begin
      fault_event <= 1'b0;
      case (state_reg)
        vds_pkg::ST_OFF: begin
          // level start: a bridge re-enabled by a status clear is blanked again
          if (on_now) begin
            state_reg     <= vds_pkg::ST_BLANK;
            blank_cnt_reg <= 10'h000;
            filt_cnt_reg  <= 8'h00;
            pre_short_reg <= 1'b0;
          end
        end
        vds_pkg::ST_BLANK: begin
          if (!on_now) begin
            state_reg <= vds_pkg::ST_OFF;
          end else begin
            // errors masked while blanking
            if (overvoltage) begin
              pre_short_reg <= 1'b1;
            end
            if (blank_cnt_reg + 10'h001 >= blank_cycles) begin
              state_reg <= vds_pkg::ST_MONITOR;
            end else begin
              blank_cnt_reg <= blank_cnt_reg + 10'h001;
            end
          end
        end
        vds_pkg::ST_MONITOR: begin
          if (!on_now) begin
            state_reg <= vds_pkg::ST_OFF;
          end else if (!overvoltage) begin
            filt_cnt_reg  <= 8'h00;
            pre_short_reg <= 1'b0;
          end else if (filt_cnt_reg + 8'h01 > filt_limit) begin
            state_reg   <= vds_pkg::ST_LATCHED;
            fault_event <= 1'b1;
          end else begin
            filt_cnt_reg <= filt_cnt_reg + 8'h01;
          end
        end
        default: begin
          // only a status clear re-enables the bridge
          if (fault_clear) begin
            state_reg <= vds_pkg::ST_OFF;
          end
        end
      endcase
    end
  end

  assign latched    = (state_reg == vds_pkg::ST_LATCHED);
  assign monitoring = (state_reg == vds_pkg::ST_MONITOR);
endmodule

// file: hw/vds_overvoltage_monitor.sv
// Summary of operation
// - compare only with enable high, not passive
// - confirmed fault latches both bridge MOSFETs off
// - ref bit 0: high-side drain sense vs node
// - ref bit 1: first current sense vs node
// - low-side: node vs low-side source sense
// - 3-bit threshold code, default 200 mV
// - error after blank plus filter time
// - 2-bit filter time, default 0.5 us
// - early static short: blank plus twice filter
// - latch-off discharge uses static current setting
// - set per-bridge fault status bit
// - set global drain-source error flag
// - bridge stays off until status cleared
// - 3-bit blank time select, errors masked
// - blank starts on turn-on command
//
// Local design decisions: the address map and the APB interface to the registers.
`timescale 1ns/1ps
`include "vds_monitor_defines.svh"
module vds_overvoltage_monitor (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic             pslverr,
  output logic [31:0]      prdata,
  input  wire logic        enable_in,
  input  wire logic [7:0]  hs_on_cmd,
  input  wire logic [7:0]  ls_on_cmd,
  input  wire logic [7:0]  hs_drain_cmp,
  input  wire logic [7:0]  hs_csense_cmp,
  input  wire logic [7:0]  ls_cmp,
  output logic [7:0]       hs_gate_enable,
  output logic [7:0]       ls_gate_enable,
  output logic [7:0]       static_discharge_sel,
  output logic [23:0]      threshold_code,
  output logic [31:0]      static_gate_current_cfg,
  output logic [7:0]       monitor_active,
  output logic             irq
);
  // comparator inputs are digital results of the analog comparators at
  // the selected threshold; threshold codes are forwarded as 3 bits each
  logic [31:0] threshold_reg_a;
  logic [31:0] threshold_reg_b;
  logic [31:0] general_control_two;
  logic [7:0]  hb_drain_ref_select;
  logic [31:0] blank_time_select;
  logic [7:0]  drain_source_fault_status;
  logic [7:0]  irq_mask_reg;
  logic        global_drain_source_error;
  logic [7:0]  fault_event;
  logic [7:0]  latched;
  logic        active_mode;
  logic        wr_en;
  logic        rd_en;
  logic        addr_ok;
  logic [31:0] rdata_next;
  logic [6:0]  filter_cycles;
  logic [7:0]  fault_clear;
  logic [7:0]  overvoltage;

  assign pready  = 1'b1;
  assign wr_en   = psel & penable & pwrite;
  assign rd_en   = psel & penable & ~pwrite;
  assign pslverr = psel & penable & ~addr_ok;

  always_comb begin
    addr_ok    = 1'b1;
    rdata_next = 32'h00000000;
    if (paddr == `OFF_THR_A) begin
      rdata_next = threshold_reg_a;
    end else if (paddr == `OFF_THR_B) begin
      rdata_next = threshold_reg_b;
    end else if (paddr == `OFF_GEN_CTRL_TWO) begin
      rdata_next = general_control_two;
    end else if (paddr == `OFF_DRAIN_REF) begin
      rdata_next = {24'h000000, hb_drain_ref_select};
    end else if (paddr == `OFF_BLANK_SEL_LO) begin
      rdata_next = {16'h0000, blank_time_select[15:0]};
    end else if (paddr == `OFF_BLANK_SEL_HI) begin
      rdata_next = {16'h0000, blank_time_select[31:16]};
    end else if (paddr == `OFF_STATIC_CFG) begin
      rdata_next = static_gate_current_cfg;
    end else if (paddr == `OFF_FAULT_STATUS) begin
      rdata_next = {24'h000000, drain_source_fault_status};
    end else if (paddr == `OFF_IRQ_MASK) begin
      rdata_next = {24'h000000, irq_mask_reg};
    end else if (paddr == `OFF_GLOBAL_STATUS) begin
      rdata_next = {31'h00000000, global_drain_source_error};
    end else if (paddr == `OFF_PIN_STATE) begin
      rdata_next = {8'h00, monitor_active, ls_gate_enable, hs_gate_enable};
    end else begin
      addr_ok = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (psel && !penable && !pwrite) begin
      prdata <= rdata_next;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      threshold_reg_a         <= `RST_THR_A;
      threshold_reg_b         <= `RST_THR_B;
      general_control_two     <= `RST_GEN_CTRL_TWO;
      hb_drain_ref_select     <= 8'h00;
      blank_time_select       <= `RST_BLANK_SEL;
      static_gate_current_cfg <= `RST_STATIC_CFG;
      irq_mask_reg            <= 8'h00;
    end else if (wr_en) begin
      if (paddr == `OFF_THR_A) begin
        threshold_reg_a <= {20'h00000, pwdata[11:0]};
      end else if (paddr == `OFF_THR_B) begin
        threshold_reg_b <= {20'h00000, pwdata[11:0]};
      end else if (paddr == `OFF_GEN_CTRL_TWO) begin
        general_control_two <= {29'h00000000, pwdata[2:0]};
      end else if (paddr == `OFF_DRAIN_REF) begin
        hb_drain_ref_select <= pwdata[7:0];
      end else if (paddr == `OFF_BLANK_SEL_LO) begin
        blank_time_select[15:0] <= pwdata[15:0];
      end else if (paddr == `OFF_BLANK_SEL_HI) begin
        blank_time_select[31:16] <= pwdata[15:0];
      end else if (paddr == `OFF_STATIC_CFG) begin
        static_gate_current_cfg <= pwdata;
      end else if (paddr == `OFF_IRQ_MASK) begin
        irq_mask_reg <= pwdata[7:0];
      end
    end
  end

  // code 111 passes through; choosing it is the controller's concern
  assign threshold_code = {threshold_reg_b[11:0], threshold_reg_a[11:0]};

  assign active_mode = enable_in & ~general_control_two[`GC2_PASSIVE_BIT];

  always_comb begin
    case (general_control_two[`GC2_FILTER_LSB +: 2])
      2'h0:    filter_cycles = 7'(`NS_TO_CYC(`FILT_T0_NS));
      2'h1:    filter_cycles = 7'(`NS_TO_CYC(`FILT_T1_NS));
      2'h2:    filter_cycles = 7'(`NS_TO_CYC(`FILT_T2_NS));
      default: filter_cycles = 7'(`NS_TO_CYC(`FILT_T3_NS));
    endcase
  end

  function automatic logic [9:0] blank_lookup(input logic [2:0] code);
    case (code)
      3'h0:    blank_lookup = 10'(`NS_TO_CYC(`BLANK_T0_NS));
      3'h1:    blank_lookup = 10'(`NS_TO_CYC(`BLANK_T1_NS));
      3'h2:    blank_lookup = 10'(`NS_TO_CYC(`BLANK_T2_NS));
      3'h3:    blank_lookup = 10'(`NS_TO_CYC(`BLANK_T3_NS));
      3'h4:    blank_lookup = 10'(`NS_TO_CYC(`BLANK_T4_NS));
      3'h5:    blank_lookup = 10'(`NS_TO_CYC(`BLANK_T5_NS));
      3'h6:    blank_lookup = 10'(`NS_TO_CYC(`BLANK_T6_NS));
      default: blank_lookup = 10'(`NS_TO_CYC(`BLANK_T7_NS));
    endcase
  endfunction

  genvar gi;
  generate
    for (gi = 0; gi < 8; gi = gi + 1) begin : g_bridge
      logic [9:0] blank_cycles;
      assign blank_cycles = blank_lookup(blank_time_select[4*gi +: 3]);
      // high-side reference chosen per bridge; low-side vs source sense
      assign overvoltage[gi] =
          (hs_on_cmd[gi] & (hb_drain_ref_select[gi] ? hs_csense_cmp[gi]
                                                    : hs_drain_cmp[gi])) |
          (ls_on_cmd[gi] & ls_cmp[gi]);
      // clear write of a one drops the latch; set still wins in status
      assign fault_clear[gi] = wr_en & (paddr == `OFF_FAULT_STATUS) & pwdata[gi];

      vds_channel u_chan (
        .pclk          (pclk),
        .presetn       (presetn),
        .active_mode   (active_mode),
        .hs_on_cmd     (hs_on_cmd[gi]),
        .ls_on_cmd     (ls_on_cmd[gi]),
        .overvoltage   (overvoltage[gi]),
        .blank_cycles  (blank_cycles),
        .filter_cycles (filter_cycles),
        .fault_clear   (fault_clear[gi]),
        .fault_event   (fault_event[gi]),
        .latched       (latched[gi]),
        .monitoring    (monitor_active[gi])
      );

      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          hs_gate_enable[gi]       <= 1'b0;
          ls_gate_enable[gi]       <= 1'b0;
          static_discharge_sel[gi] <= 1'b0;
        end else begin
          // latched bridge: both off, discharged as a static turn-off
          hs_gate_enable[gi]       <= hs_on_cmd[gi] & ~latched[gi] & ~fault_event[gi];
          ls_gate_enable[gi]       <= ls_on_cmd[gi] & ~latched[gi] & ~fault_event[gi];
          static_discharge_sel[gi] <= latched[gi] | fault_event[gi];
        end
      end

      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          drain_source_fault_status[gi] <= 1'b0;
        end else if (fault_event[gi]) begin
          drain_source_fault_status[gi] <= 1'b1;
        end else if (fault_clear[gi]) begin
          drain_source_fault_status[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      global_drain_source_error <= 1'b0;
    end else begin
      // follows the per-bridge status so a full clear also drops it
      global_drain_source_error <= (|fault_event) |
          (|(drain_source_fault_status & ~fault_clear));
    end
  end

  assign irq = |(drain_source_fault_status & irq_mask_reg);
endmodule

// file: testbench/bridge_model.sv
`timescale 1ns/1ps
// comparators trip only while the MOSFET is driven on and a short is injected
module bridge_model (
  input  wire logic [7:0] hs_gate_enable,
  input  wire logic [7:0] ls_gate_enable,
  input  wire logic [7:0] short_hs,
  input  wire logic [7:0] short_cs,
  input  wire logic [7:0] short_ls,
  output logic      [7:0] hs_drain_cmp,
  output logic      [7:0] hs_csense_cmp,
  output logic      [7:0] ls_cmp
);
  assign hs_drain_cmp  = hs_gate_enable & short_hs;
  assign hs_csense_cmp = hs_gate_enable & short_cs;
  assign ls_cmp        = ls_gate_enable & short_ls;
endmodule

// file: testbench/vds_monitor_asserts.sv
`timescale 1ns/1ps
`include "vds_monitor_defines.svh"
module vds_monitor_asserts (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        enable_in,
  input wire logic [7:0]  hs_on_cmd,
  input wire logic [7:0]  hs_drain_cmp,
  input wire logic [7:0]  hs_csense_cmp,
  input wire logic [7:0]  ls_cmp,
  input wire logic [7:0]  hs_gate_enable,
  input wire logic [7:0]  ls_gate_enable,
  input wire logic [7:0]  static_discharge_sel,
  input wire logic [7:0]  monitor_active,
  input wire logic        irq
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [7:0] over_cnt;
  logic       clr0;
  // saturates so a long short never wraps back under the filter figure
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) over_cnt <= 8'h00;
    else if (!(hs_drain_cmp[0] | hs_csense_cmp[0] | ls_cmp[0])) over_cnt <= 8'h00;
    else if (over_cnt != 8'hFF) over_cnt <= over_cnt + 8'h01;
  end
  assign clr0 = psel & penable & pwrite & (paddr == `OFF_FAULT_STATUS) & pwdata[0];
  latch_off_a: assert property ((static_discharge_sel & (hs_gate_enable | ls_gate_enable)) == 8'h00)
    else $error("gate driven while latched off");
  hold_off_a: assert property (static_discharge_sel[0] && hs_on_cmd[0] && !clr0
      && !$past(clr0) |=> static_discharge_sel[0])
    else $error("latch released without status clear");
  filter_hold_a: assert property ($rose(static_discharge_sel[0]) |-> over_cnt >= 8'h0D)
    else $error("latch before filter time");
  blank_mask_a: assert property ($rose(hs_on_cmd[0]) |-> !monitor_active[0] [*8])
    else $error("monitoring during blank time");
  no_monitor_a: assert property (!enable_in ##1 !enable_in |-> monitor_active == 8'h00)
    else $error("monitoring with enable low");
  irq_fault_a: assert property ($rose(irq) |-> static_discharge_sel != 8'h00)
    else $error("interrupt without fault");
  apb_ready_a: assert property (psel && penable |-> pready)
    else $error("access phase not ready");
  apb_unmapped_a: assert property (psel && penable && paddr > `OFF_PIN_STATE |-> pslverr)
    else $error("unmapped access not refused");
  cover property ($rose(static_discharge_sel[0]));
  cover property ($rose(irq));
  cover property (psel && penable && pslverr);
endmodule
bind vds_overvoltage_monitor vds_monitor_asserts vds_monitor_asserts_inst (.pclk, .presetn,
  .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .pslverr, .enable_in, .hs_on_cmd,
  .hs_drain_cmp, .hs_csense_cmp, .ls_cmp, .hs_gate_enable, .ls_gate_enable,
  .static_discharge_sel, .monitor_active, .irq);

// file: testbench/tb_top.sv
`timescale 1ns/1ps
`include "vds_monitor_defines.svh"
module tb_top;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic        enable_in = 1'b1, pready, pslverr, irq, err;
  logic [7:0]  paddr = 8'h00, hs_on_cmd = 8'h00, ls_on_cmd = 8'h00;
  logic [7:0]  short_hs = 8'h00, short_cs = 8'h00, short_ls = 8'h00;
  logic [7:0]  hs_drain_cmp, hs_csense_cmp, ls_cmp, hs_gate_enable, ls_gate_enable;
  logic [7:0]  static_discharge_sel, monitor_active;
  logic [23:0] threshold_code;
  logic [31:0] pwdata = 32'h0, prdata, static_gate_current_cfg, rd;
  int          n_errors = 0, compares = 0, cycles = 0;
  always #20 pclk = ~pclk;
  vds_overvoltage_monitor vds_overvoltage_monitor_inst (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .pready, .pslverr, .prdata, .enable_in, .hs_on_cmd, .ls_on_cmd,
    .hs_drain_cmp, .hs_csense_cmp, .ls_cmp, .hs_gate_enable, .ls_gate_enable,
    .static_discharge_sel, .threshold_code, .static_gate_current_cfg, .monitor_active, .irq);
  bridge_model bridge_model_inst (.hs_gate_enable, .ls_gate_enable, .short_hs, .short_cs,
    .short_ls, .hs_drain_cmp, .hs_csense_cmp, .ls_cmp);
  task test_done();
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // whole run needs about 4k cycles
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 40000) begin
      n_errors++;
      test_done();
    end
  end
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask
  function automatic logic gate_on();
    return hs_gate_enable[0] | ls_gate_enable[0];
  endfunction
  task wait_mon(output int n);
    for (n = 0; n < 600 && monitor_active[0] !== 1'b1; n++) @(posedge pclk);
  endtask
  // lo/hi bound the cycles until the bridge drops; 300 means it must stay on
  task trial(input logic ls, input logic cs, input logic early, input int lo, input int hi);
    int n;
    @(posedge pclk);
    if (ls) ls_on_cmd <= 8'h01; else hs_on_cmd <= 8'h01;
    if (!early) wait_mon(n);
    if (ls) short_ls <= 8'h01; else if (cs) short_cs <= 8'h01; else short_hs <= 8'h01;
    n = 0;
    do begin @(posedge pclk); n++; end while ((n < 2 || gate_on() === 1'b1) && n < 300);
    chk("off_time", n >= lo && n <= hi, 1'b1);
    if (hi < 300) begin
      @(negedge pclk);
      chk("discharge_sel", static_discharge_sel[0], 1'b1);
      chk("irq_set", irq, 1'b1);
      apb(1'b1, `OFF_IRQ_MASK, 32'h0);
      @(negedge pclk);
      chk("irq_masked", irq, 1'b0);
      apb(1'b0, `OFF_FAULT_STATUS, 32'h0);
      chk("fault_status", rd, 32'h1);
      apb(1'b0, `OFF_GLOBAL_STATUS, 32'h0);
      chk("global_error", rd[`GS_GLOBAL_DRAIN_SOURCE_ERROR_BIT], 1'b1);
      repeat (20) @(posedge pclk);
      chk("held_off", gate_on(), 1'b0);
      short_hs <= 8'h00; short_cs <= 8'h00; short_ls <= 8'h00;
      apb(1'b1, `OFF_FAULT_STATUS, 32'h1);
      apb(1'b1, `OFF_IRQ_MASK, 32'h1);
      repeat (3) @(posedge pclk);
      @(negedge pclk);
      chk("reenabled", gate_on(), 1'b1);
      chk("irq_clear", irq, 1'b0);
      wait_mon(n);
      chk("remonitor", monitor_active[0], 1'b1);
    end
    @(posedge pclk);
    hs_on_cmd <= 8'h00; ls_on_cmd <= 8'h00;
    short_hs <= 8'h00; short_cs <= 8'h00; short_ls <= 8'h00;
    repeat (5) @(posedge pclk);
  endtask
  // short bursts under the filter time must never latch
  task glitch();
    int n;
    @(posedge pclk);
    hs_on_cmd <= 8'h01;
    wait_mon(n);
    chk("blank_len", n >= 50 && n <= 54, 1'b1);
    repeat (3) begin
      short_hs <= 8'h01;
      repeat (10) @(posedge pclk);
      short_hs <= 8'h00;
      @(posedge pclk);
    end
    @(negedge pclk);
    chk("no_fault", gate_on(), 1'b1);
    @(posedge pclk);
    hs_on_cmd <= 8'h00;
    repeat (5) @(posedge pclk);
  endtask
  task blank_try(input logic [2:0] code, input int b);
    int n;
    apb(1'b1, `OFF_BLANK_SEL_LO, {29'h00000000, code});
    @(posedge pclk);
    hs_on_cmd <= 8'h01;
    wait_mon(n);
    chk("blank_code", n >= b && n <= b + 4, 1'b1);
    @(posedge pclk);
    hs_on_cmd <= 8'h00;
    repeat (5) @(posedge pclk);
  endtask
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(negedge pclk);
    chk("thr_reset", threshold_code, 24'h249249);
    apb(1'b0, `OFF_GEN_CTRL_TWO, 32'h0);
    chk("gc2_reset", rd, `RST_GEN_CTRL_TWO);
    apb(1'b1, `OFF_THR_A, 32'h0);
    @(negedge pclk);
    chk("thr_write", threshold_code, 24'h249000);
    apb(1'b0, 8'h40, 32'h0);
    chk("unmapped", err, 1'b1);
    chk("unmapped_rd", rd, 32'h0);
    apb(1'b1, `OFF_STATIC_CFG, 32'hA5A51234);
    @(negedge pclk);
    chk("static_cfg", static_gate_current_cfg, 32'hA5A51234);
    apb(1'b1, `OFF_IRQ_MASK, 32'h1);
    trial(1'b0, 1'b0, 1'b0, 14, 19);
    trial(1'b1, 1'b0, 1'b0, 14, 19);
    apb(1'b1, `OFF_DRAIN_REF, 32'h1);
    trial(1'b0, 1'b0, 1'b0, 300, 300);
    trial(1'b0, 1'b1, 1'b0, 14, 19);
    apb(1'b1, `OFF_DRAIN_REF, 32'h0);
    trial(1'b0, 1'b0, 1'b1, 76, 84);
    glitch();
    blank_try(3'h0, 16);
    blank_try(3'h7, 400);
    apb(1'b1, `OFF_BLANK_SEL_LO, 32'h00004444);
    apb(1'b1, `OFF_GEN_CTRL_TWO, 32'h1);
    trial(1'b0, 1'b0, 1'b0, 26, 31);
    apb(1'b1, `OFF_GEN_CTRL_TWO, 32'h2);
    trial(1'b0, 1'b0, 1'b0, 51, 56);
    apb(1'b1, `OFF_GEN_CTRL_TWO, 32'h3);
    trial(1'b0, 1'b0, 1'b0, 76, 81);
    apb(1'b1, `OFF_GEN_CTRL_TWO, 32'h4);
    trial(1'b0, 1'b0, 1'b0, 300, 300);
    apb(1'b1, `OFF_GEN_CTRL_TWO, 32'h0);
    enable_in <= 1'b0;
    trial(1'b0, 1'b0, 1'b0, 300, 300);
    test_done();
  end
endmodule
